// ===== include/metering_cfg_pkg.sv
// Package for the computation-mode and gain configuration bank.
// Assumes a single 20 MHz clock and a plain register port.
package metering_cfg_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;

  localparam logic [15:0] COMPUTATION_MODE_CONFIG_OFFSET = 16'hE60E;
  localparam logic [15:0] GAIN_SELECT_OFFSET             = 16'hE60F;

  localparam int unsigned ANGLE_SEL_LSB   = 9;
  localparam int unsigned NOMINAL_VOLTAGE_VALUE_A_EN_BIT   = 11;
  localparam int unsigned NOMINAL_VOLTAGE_VALUE_B_EN_BIT   = 12;
  localparam int unsigned NOMINAL_VOLTAGE_VALUE_C_EN_BIT   = 13;
  localparam int unsigned LINE_FREQ_BIT   = 14;
  localparam int unsigned MODE_SPARE_BIT  = 15;

  localparam int unsigned PH_I_GAIN_LSB   = 0;
  localparam int unsigned N_I_GAIN_LSB    = 3;
  localparam int unsigned PH_V_GAIN_LSB   = 6;
  localparam int unsigned GAIN_FIELD_W    = 3;

  // Bits [8:0] of the mode register are kept by another block.
  localparam logic [15:0] MODE_OWNED_MASK = 16'h7E00;
  localparam logic [15:0] GAIN_USED_MASK  = 16'h01FF;
  localparam logic [15:0] MODE_RESET      = 16'h0000;
  localparam logic [15:0] GAIN_RESET      = 16'h0000;

  localparam logic [2:0] GAIN_CODE_MAX    = 3'h4;

  typedef enum logic [1:0] {
    ANGLE_V_TO_I  = 2'h0,
    ANGLE_V_TO_V  = 2'h1,
    ANGLE_I_TO_I  = 2'h2,
    ANGLE_NONE    = 2'h3
  } angle_mode_t;

endpackage

// ===== verilog/gain_code_decode.sv
// Gain field decoder: maps a 3-bit gain code to a one-hot gain and shift.
// Assumes the code comes from a register on the same clock.
`timescale 1ns/1ps
module gain_code_decode
  import metering_cfg_pkg::*;
(
  input  wire logic [2:0] code,
  output logic      [2:0] shiftAmount,
  output logic      [4:0] gainOneHot
);

  logic codeValid;

  // Reserved codes fall back to unity gain.
  assign codeValid   = (code <= GAIN_CODE_MAX);
  assign shiftAmount = codeValid ? code : 3'h0;
  assign gainOneHot  = 5'h01 << shiftAmount;

endmodule

// ===== verilog/metering_compute_gain_config.sv
// Computation-mode and gain configuration bank with datapath decode.
// Assumes the register master is on mclk and strobes are never both high.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module metering_compute_gain_config
  import metering_cfg_pkg::*;
#(
  parameter bit HAS_NEUTRAL      = 1'b1,
  parameter bit HAS_FUNDAMENTAL  = 1'b1,
  parameter int unsigned VRMS_W  = 24
)(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWrStrobe,
  input  wire logic              regRdStrobe,
  output logic      [DATA_W-1:0] regRdData,
  input  wire logic [VRMS_W-1:0] nominalVoltageValue,
  input  wire logic [VRMS_W-1:0] measVrmsA,
  input  wire logic [VRMS_W-1:0] measVrmsB,
  input  wire logic [VRMS_W-1:0] measVrmsC,
  output logic      [VRMS_W-1:0] vrmsA,
  output logic      [VRMS_W-1:0] vrmsB,
  output logic      [VRMS_W-1:0] vrmsC,
  output logic      [2:0]        nominalVoltageEnable,
  output logic                   phaseVoltageInputIgnoreA,
  output logic                   phaseVoltageInputIgnoreB,
  output logic                   phaseVoltageInputIgnoreC,
  output logic                   angleVoltToCurrent,
  output logic                   angleVoltToVolt,
  output logic                   angleCurrToCurrent,
  output logic                   angleMeasureActive,
  output logic                   lineFrequency60Hz,
  output logic      [2:0]        phaseCurrentShift,
  output logic      [2:0]        neutralCurrentShift,
  output logic      [2:0]        phaseVoltageShift,
  output logic      [4:0]        phaseCurrentGainOneHot,
  output logic      [4:0]        neutralCurrentGainOneHot,
  output logic      [4:0]        phaseVoltageGainOneHot
);

  initial begin
    if (VRMS_W < 1 || VRMS_W > 32) begin
      $error("VRMS_W must lie between 1 and 32");
    end
  end

  logic [15:0] modeReg_q;
  logic [15:0] modeReg_d;
  logic [15:0] gainReg_q;
  logic [15:0] gainReg_d;
  logic [15:0] rdData_q;
  logic [15:0] rdData_d;

  logic        hitMode;
  logic        hitGain;
  logic        wrMode;
  logic        wrGain;
  logic [15:0] gainWriteMask;

  logic [1:0]  angle_measure_select;
  angle_mode_t angleMode;
  logic [2:0]  phaseCurrentCode;
  logic [2:0]  neutralCurrentCode;
  logic [2:0]  phaseVoltageCode;

  assign hitMode = (regAddr == COMPUTATION_MODE_CONFIG_OFFSET);
  assign hitGain = (regAddr == GAIN_SELECT_OFFSET);
  assign wrMode  = regWrStrobe && hitMode;
  assign wrGain  = regWrStrobe && hitGain;

  // neutral gain pinned
  // The neutral field is not writable when the channel is absent.
  assign gainWriteMask = HAS_NEUTRAL ? GAIN_USED_MASK
                                     : (GAIN_USED_MASK & 16'hFFC7);

  // reserved gain bits zero
  // Only the bits owned here are stored; the rest stay at their resets.
  assign modeReg_d = wrMode ? (regWrData & MODE_OWNED_MASK) : modeReg_q;
  assign gainReg_d = wrGain ? (regWrData & gainWriteMask)   : gainReg_q;

  // Unmapped addresses read as zero.
  assign rdData_d = !regRdStrobe ? 16'h0000 :
                    hitMode      ? modeReg_q :
                    hitGain      ? gainReg_q : 16'h0000;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      modeReg_q <= MODE_RESET;
      gainReg_q <= GAIN_RESET;
      rdData_q  <= 16'h0000;
    end else begin
      modeReg_q <= modeReg_d;
      gainReg_q <= gainReg_d;
      rdData_q  <= rdData_d;
    end
  end

  assign regRdData = rdData_q;

  assign angle_measure_select           = modeReg_q[ANGLE_SEL_LSB +: 2];
  assign angleMode          = angle_mode_t'(angle_measure_select);
  assign angleVoltToCurrent = (angleMode == ANGLE_V_TO_I);
  assign angleVoltToVolt    = (angleMode == ANGLE_V_TO_V);
  assign angleCurrToCurrent = (angleMode == ANGLE_I_TO_I);
  assign angleMeasureActive = (angleMode != ANGLE_NONE);

  assign nominalVoltageEnable[0] = modeReg_q[NOMINAL_VOLTAGE_VALUE_A_EN_BIT];
  assign nominalVoltageEnable[1] = modeReg_q[NOMINAL_VOLTAGE_VALUE_B_EN_BIT];
  assign nominalVoltageEnable[2] = modeReg_q[NOMINAL_VOLTAGE_VALUE_C_EN_BIT];

  assign phaseVoltageInputIgnoreA = nominalVoltageEnable[0];
  assign phaseVoltageInputIgnoreB = nominalVoltageEnable[1];
  assign phaseVoltageInputIgnoreC = nominalVoltageEnable[2];

  // Each rms voltage use picks the nominal value when substitution is on.
  assign vrmsA = nominalVoltageEnable[0] ? nominalVoltageValue : measVrmsA;
  assign vrmsB = nominalVoltageEnable[1] ? nominalVoltageValue : measVrmsB;
  assign vrmsC = nominalVoltageEnable[2] ? nominalVoltageValue : measVrmsC;

  // frequency select
  // Variants without fundamental processing see 50 Hz whatever is written.
  assign lineFrequency60Hz = HAS_FUNDAMENTAL && modeReg_q[LINE_FREQ_BIT];

  assign phaseCurrentCode   = gainReg_q[PH_I_GAIN_LSB +: GAIN_FIELD_W];
  assign neutralCurrentCode = gainReg_q[N_I_GAIN_LSB  +: GAIN_FIELD_W];
  assign phaseVoltageCode   = gainReg_q[PH_V_GAIN_LSB +: GAIN_FIELD_W];

  gain_code_decode uPhaseCurrent (
    .code        (phaseCurrentCode),
    .shiftAmount (phaseCurrentShift),
    .gainOneHot  (phaseCurrentGainOneHot)
  );

  gain_code_decode uNeutralCurrent (
    .code        (neutralCurrentCode),
    .shiftAmount (neutralCurrentShift),
    .gainOneHot  (neutralCurrentGainOneHot)
  );

  gain_code_decode uPhaseVoltage (
    .code        (phaseVoltageCode),
    .shiftAmount (phaseVoltageShift),
    .gainOneHot  (phaseVoltageGainOneHot)
  );

endmodule

// ===== verification/metering_cfg_properties.sv
// Checker for the mode and gain bank, bound to its top module.
// Assumes writes show on the outputs one cycle after the strobe edge.
`timescale 1ns/1ps
module metering_cfg_properties
  import metering_cfg_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWrStrobe,
  input wire logic        regRdStrobe,
  input wire logic [15:0] regRdData,
  input wire logic [2:0]  nominalVoltageEnable,
  input wire logic        angleVoltToVolt,
  input wire logic        angleMeasureActive,
  input wire logic        lineFrequency60Hz,
  input wire logic [2:0]  phaseCurrentShift,
  input wire logic [2:0]  neutralCurrentShift,
  input wire logic [2:0]  phaseVoltageShift
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  function automatic logic [2:0] sh(logic [2:0] c);
    return (c <= 3'h4) ? c : 3'h0;
  endfunction
  sequence modeWr; regWrStrobe && regAddr == 16'hE60E; endsequence
  sequence gainWr; regWrStrobe && regAddr == 16'hE60F; endsequence
  a_angle_vv: assert property (modeWr |=>
    angleVoltToVolt == ($past(regWrData[10:9]) == 2'h1)) else $error("vv");
  a_angle_off: assert property (modeWr |=>
    angleMeasureActive == ($past(regWrData[10:9]) != 2'h3)) else $error("an");
  a_nominal_bits: assert property (modeWr |=>
    nominalVoltageEnable == $past(regWrData[13:11])) else $error("nv");
  a_line_freq: assert property (modeWr |=>
    lineFrequency60Hz == $past(regWrData[14])) else $error("lf");
  a_reserved_read: assert property (regRdStrobe |=>
    (regRdData & ~($past(regAddr) == 16'hE60E ? 16'h7E00 :
    $past(regAddr) == 16'hE60F ? 16'h01FF : 16'h0000)) == 16'h0000)
    else $error("rsvd");
  a_phase_gain: assert property (gainWr |=>
    phaseCurrentShift == sh($past(regWrData[2:0]))) else $error("pi");
  a_neutral_gain: assert property (gainWr |=>
    neutralCurrentShift == sh($past(regWrData[5:3]))) else $error("ni");
  a_volt_gain: assert property (gainWr |=>
    phaseVoltageShift == sh($past(regWrData[8:6]))) else $error("pv");
endmodule
bind metering_compute_gain_config metering_cfg_properties chk (.mclk,
  .rst_n, .regAddr, .regWrData, .regWrStrobe, .regRdStrobe, .regRdData,
  .nominalVoltageEnable, .angleVoltToVolt, .angleMeasureActive,
  .lineFrequency60Hz, .phaseCurrentShift, .neutralCurrentShift,
  .phaseVoltageShift);

// ===== verification/metering_compute_gain_config_tb.sv
// Self-checking bench for the mode and gain configuration bank.
// Assumes the checker file is compiled beside the design.
`timescale 1ns/1ps
module metering_compute_gain_config_tb
  import metering_cfg_pkg::*;
;
  logic        mclk = 1'b0, rst_n = 1'b0, wrS = 1'b0, rdS = 1'b0;
  logic        rdSeen = 1'b0, avi, lf;
  logic [23:0] vB;
  logic [15:0] addr = 16'h0000, wd = 16'h0000, rdData;
  logic [23:0] nomV = 24'h000000, mA = 24'h000000, vA;
  logic [2:0]  pis, nis, pvs;
  logic [15:0] expQ[$];
  int          nMismatch = 0, checked = 0, cyc = 0, seed = 40041;
  metering_compute_gain_config metering_compute_gain_config_inst (
    .mclk, .rst_n, .regAddr(addr), .regWrData(wd), .regWrStrobe(wrS),
    .regRdStrobe(rdS), .regRdData(rdData), .nominalVoltageValue(nomV),
    .measVrmsA(mA), .measVrmsB(mA), .measVrmsC(nomV), .vrmsA(vA),
    .vrmsB(vB), .vrmsC(), .nominalVoltageEnable(),
    .phaseVoltageInputIgnoreA(), .phaseVoltageInputIgnoreB(),
    .phaseVoltageInputIgnoreC(), .angleVoltToCurrent(avi),
    .angleVoltToVolt(), .angleCurrToCurrent(), .angleMeasureActive(),
    .lineFrequency60Hz(lf), .phaseCurrentShift(pis),
    .neutralCurrentShift(nis), .phaseVoltageShift(pvs),
    .phaseCurrentGainOneHot(), .neutralCurrentGainOneHot(),
    .phaseVoltageGainOneHot());
  task automatic cmp(logic [23:0] got, exp);
    checked++;
    if (got !== exp) begin
      nMismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [15:0] a, d);
    @(posedge mclk);
    addr <= a;
    wd <= d;
    wrS <= 1'b1;
    @(posedge mclk);
    wrS <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [15:0] a, e);
    @(posedge mclk);
    addr <= a;
    rdS <= 1'b1;
    expQ.push_back(e);
    @(posedge mclk);
    rdS <= 1'b0;
  endtask
  task final_report;
    if (nMismatch == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe.
  always @(posedge mclk) rdSeen <= rdS;
  always @(negedge mclk) if (rdSeen) cmp({8'h00, rdData}, expQ.pop_front());
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      nMismatch++;
      final_report;
    end
  end
  initial forever #25 mclk = ~mclk;
  initial begin
    logic [15:0] d;
    logic [2:0]  c;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    nomV <= 24'($random(seed));
    mA <= 24'($random(seed));
    rd(16'hE60E, 16'h0000);
    rd(16'hE60F, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      d = {7'($random(seed)), c, c, c};
      wr(16'hE60F, d);
      cmp({pis, nis, pvs}, {3{(c <= 3'h4) ? c : 3'h0}});
      rd(16'hE60F, d & 16'h01FF);
    end
    for (int i = 0; i < 4; i++) begin
      d = 16'($random(seed));
      d[10:9] = 2'(i);
      d[11] = i[0];
      d[12] = i[1];
      d[14] = i[0];
      wr(16'hE60E, d);
      cmp({23'h0, avi}, {23'h0, i == 0});
      cmp(vA, d[11] ? nomV : mA);
      cmp(vB, d[12] ? nomV : mA);
      cmp({23'h0, lf}, {23'h0, d[14]});
      rd(16'hE60E, d & 16'h7E00);
    end
    wr(16'hE610, 16'hFFFF);
    rd(16'hE610, 16'h0000);
    rd(16'hE60E, d & 16'h7E00);
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    rd(16'hE60E, 16'h0000);
    repeat (2) @(posedge mclk);
    final_report;
  end
endmodule
